// ---- hw/ukp_consts.vh ----
/*
 Constants for the uplink keycode update path: widths, field positions,
 reset values, order code values and telemetry byte sizes.
 Assumes inclusion by bare name from the design files.
*/
`ifndef UKP_CONSTS_VH
`define UKP_CONSTS_VH
`define UKP_KEY_W        5
`define UKP_MSG_W        22
`define UKP_MARK_POS     7
`define UKP_TRIPLE_W     15
`define UKP_DIGIT_W      3
`define UKP_DIGITS       5
`define UKP_WORD_W       16
`define UKP_STAGE_WORDS  14
`define UKP_VER_W        40
`define UKP_TM_W         8
`define UKP_TM_BYTES     5
`define UKP_PAR_LO       15
`define UKP_PAR_HI       31
`define UKP_ORDER_LO     32
`define UKP_ORDER_MARKER 8'h01
`define UKP_ORDER_IDENT  8'h02
`define UKP_ORDER_DATA   8'h03
`define UKP_CNT_RESET    16'h0000
`define UKP_KEY_DIGIT_MASK 5'h10
`endif

// ---- hw/ukp_odd_parity.v ----
/*
 Odd parity generator over a data word.
 Assumes a purely combinational use; no clock.
*/
`timescale 1ns/10ps
`default_nettype none
module ukp_odd_parity #(
   parameter W = 15
) (
   input  wire [W-1:0] dataIn,
   output wire         parityBit
);
   // The bit makes the total count of ones odd.
   assign parityBit = ~(^dataIn);
endmodule // ukp_odd_parity
`default_nettype wire

// ---- hw/ukp_triple_check.v ----
/*
 Checks a 15-bit keycode triple: keycode, complement, keycode.
 Assumes the triple is presented in parallel, most significant keycode first.
*/
`timescale 1ns/10ps
`default_nettype none
module ukp_triple_check #(
   parameter KW = 5
) (
   input  wire [3*KW-1:0] triple,
   output wire            tripleOk,
   output wire [KW-1:0]   keycode
);
   assign keycode  = triple[3*KW-1:2*KW];
   assign tripleOk = (triple[2*KW-1:KW] == ~keycode) && (triple[KW-1:0] == keycode);
endmodule // ukp_triple_check
`default_nettype wire

// ---- hw/ukp_uplink_keycode_update_path.v ----
/*
 Uplink keycode update path: receiver strip and address check, uplink
 counter, keycode holding area, triple check, assembly, staging, final
 enter and verification word telemetry.
 Assumes sub-bit decoded symbols arrive one per enabled cycle with a
 symbol-valid strobe, and that all inputs are synchronous to core_clk.
*/
`timescale 1ns/10ps
`default_nettype none
`include "ukp_consts.vh"
module ukp_uplink_keycode_update_path #(
   parameter [2:0] VEHICLE_ADDR = 3'h1,
   parameter [2:0] SYSTEM_ADDR  = 3'h2,
   parameter       STAGE_WORDS  = `UKP_STAGE_WORDS
) (
   input  wire        core_clk,
   input  wire        sys_rst,
   input  wire        clkEn,
   input  wire        symValid,
   input  wire        symBit,
   input  wire        symVehicleErr,
   input  wire        symSystemErr,
   input  wire        msgStart,
   input  wire        msgEnd,
   input  wire        kbdValid,
   input  wire [4:0]  kbdKeycode,
   input  wire        enterCmd,
   input  wire        finalEnterCmd,
   input  wire [3:0]  useAddr,
   input  wire [7:0]  orderCode,
   input  wire        tmReady,
   output reg         uplinkIrq,
   output reg  [14:0] holdArea,
   output reg         keyValid,
   output reg  [4:0]  keyOut,
   output reg         keyReject,
   output reg  [14:0] asmReg,
   output reg  [2:0]  asmCount,
   output wire        asmFull,
   output reg  [3:0]  stageCount,
   output reg         stageLive,
   output reg  [15:0] useWord,
   output reg         useParityErr,
   output reg  [7:0]  tmByte,
   output reg         tmValid
);
   localparam ST_IDLE = 3'b001;
   localparam ST_ADDR = 3'b010;
   localparam ST_DATA = 3'b100;
   localparam [2:0] TM_BYTES = `UKP_TM_BYTES;

   reg  [2:0]  state;
   reg  [2:0]  next_state;
   reg  [4:0]  bitCnt;
   reg  [5:0]  addrShift;
   reg  [15:0] uplinkCounter;
   reg  [15:0] stageMem [0:STAGE_WORDS-1];
   reg         trigCheck;
   reg  [39:0] verWord;
   reg  [2:0]  tmLeft;
   wire        tripleOk;
   wire [4:0]  tripleKey;
   wire        asmParity;
   wire        copyParity;
   wire [4:0]  selKey;
   wire        selValid;
   wire        digitKey;
   integer     i;

   assign asmFull = (asmCount == `UKP_DIGITS);

   ukp_triple_check #(.KW(`UKP_KEY_W)) uTriple (
      .triple   (holdArea),
      .tripleOk (tripleOk),
      .keycode  (tripleKey)
   );

   ukp_odd_parity #(.W(`UKP_TRIPLE_W)) uAsmPar (
      .dataIn    (asmReg),
      .parityBit (asmParity)
   );

   ukp_odd_parity #(.W(`UKP_TRIPLE_W)) uCopyPar (
      .dataIn    (asmReg),
      .parityBit (copyParity)
   );

   // Any uplink triple, good or bad, wins over the keyboard in a shared cycle; the
   // keyboard entry is lost then, which is accepted since both rarely coincide.
   assign selValid = trigCheck ? tripleOk : kbdValid;
   assign selKey   = trigCheck ? tripleKey : kbdKeycode;
   assign digitKey = (selKey & `UKP_KEY_DIGIT_MASK) == `UKP_KEY_DIGIT_MASK;

   always @* begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (symValid && msgStart) begin
               next_state = ST_ADDR;
            end
         end
         ST_ADDR: begin
            // Address errors from the sub-bit decoder abandon the message.
            if (symValid && (symVehicleErr || symSystemErr)) begin
               next_state = ST_IDLE;
            end else if (symValid && bitCnt == 5'd4) begin
               next_state = ST_DATA;
            end
         end
         ST_DATA: begin
            if (symValid && (symSystemErr || msgEnd)) begin
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state         <= ST_IDLE;
         bitCnt        <= 5'h00;
         addrShift     <= 6'h00;
         uplinkCounter <= `UKP_CNT_RESET;
         uplinkIrq     <= 1'b0;
         holdArea      <= 15'h0000;
         trigCheck     <= 1'b0;
      end else if (clkEn) begin
         state     <= next_state;
         uplinkIrq <= 1'b0;
         trigCheck <= 1'b0;
         if (state == ST_IDLE) begin
            bitCnt <= 5'h00;
         end else if (symValid) begin
            bitCnt <= bitCnt + 5'd1;
         end
         // The start symbol already carries the first vehicle address bit.
         if (state == ST_IDLE && symValid && msgStart) begin
            addrShift <= {5'h00, symBit};
         end else if (state == ST_ADDR && symValid) begin
            addrShift <= {addrShift[4:0], symBit};
         end
         // A data stream begins only if the address fields match.
         if (state == ST_ADDR && next_state == ST_DATA) begin
            if ({addrShift[4:0], symBit} != {VEHICLE_ADDR, SYSTEM_ADDR}) begin
               state <= ST_IDLE;
            end else begin
               uplinkCounter <= `UKP_CNT_RESET;
            end
         end
         // The counter is a memory word, shifted on each accepted bit.
         if (state == ST_DATA && symValid && !symSystemErr) begin
            uplinkCounter <= {uplinkCounter[14:0], symBit};
            if (uplinkCounter[14]) begin
               uplinkIrq <= 1'b1;
               holdArea  <= {uplinkCounter[13:0], symBit};
               trigCheck <= 1'b1;
               state     <= ST_IDLE;
            end
         end
      end
   end

   always @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         keyValid     <= 1'b0;
         keyOut       <= 5'h00;
         keyReject    <= 1'b0;
         asmReg       <= 15'h0000;
         asmCount     <= 3'h0;
         stageCount   <= 4'h0;
         stageLive    <= 1'b0;
         useWord      <= 16'h0000;
         useParityErr <= 1'b0;
         for (i = 0; i < STAGE_WORDS; i = i + 1) begin
            stageMem[i] <= 16'h0000;
         end
      end else if (clkEn) begin
         keyValid  <= selValid;
         keyReject <= trigCheck && !tripleOk;
         if (selValid) begin
            keyOut <= selKey;
            if (digitKey && !asmFull) begin
               asmReg   <= {asmReg[11:0], selKey[2:0]};
               asmCount <= asmCount + 3'd1;
            end
         end
         if (enterCmd && asmFull && stageCount < STAGE_WORDS) begin
            stageMem[stageCount] <= {asmParity, asmReg};
            stageCount           <= stageCount + 4'd1;
            asmCount             <= 3'h0;
            stageLive            <= 1'b0;
         end
         if (finalEnterCmd && stageCount != 4'h0) begin
            stageLive <= 1'b1;
         end
         // Staged words read as zero until released, so they cannot leak in.
         if (stageLive && useAddr < STAGE_WORDS) begin
            useWord      <= stageMem[useAddr];
            useParityErr <= ~(^stageMem[useAddr]);
         end else begin
            useWord      <= 16'h0000;
            useParityErr <= 1'b0;
         end
      end
   end

   // The echo word is built on an enter with a full assembly while no echo is pending, and shifted out a byte at a time.
   always @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         verWord <= 40'h0000000000;
         tmLeft  <= 3'h0;
         tmByte  <= 8'h00;
         tmValid <= 1'b0;
      end else if (clkEn) begin
         if (tmValid && tmReady) begin
            tmValid <= 1'b0;
         end
         if (enterCmd && asmFull && tmLeft == 3'h0) begin
            verWord <= {orderCode, copyParity, asmReg, asmParity, asmReg};
            tmLeft  <= TM_BYTES;
         end else if (tmLeft != 3'h0 && (!tmValid || tmReady)) begin
            tmByte  <= verWord[7:0];
            tmValid <= 1'b1;
            verWord <= {8'h00, verWord[39:8]};
            tmLeft  <= tmLeft - 3'd1;
         end
      end
   end
endmodule // ukp_uplink_keycode_update_path
`default_nettype wire

// ---- verification/ukp_props.sv ----
/*
 Checker for the uplink keycode update path, watching top-level ports only.
 Assumes a single core_clk domain with sys_rst as its reset.
*/
`timescale 1ns/10ps
`default_nettype none
module ukp_props (
   input wire logic        core_clk,
   input wire logic        sys_rst,
   input wire logic        enterCmd,
   input wire logic        finalEnterCmd,
   input wire logic [3:0]  useAddr,
   input wire logic        tmReady,
   input wire logic        uplinkIrq,
   input wire logic        keyValid,
   input wire logic        keyReject,
   input wire logic [14:0] asmReg,
   input wire logic [2:0]  asmCount,
   input wire logic        asmFull,
   input wire logic [3:0]  stageCount,
   input wire logic        stageLive,
   input wire logic [15:0] useWord,
   input wire logic [7:0]  tmByte,
   input wire logic        tmValid
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   irq_one_cycle_a: assert property (uplinkIrq |=> !uplinkIrq)
      else $error("overflow pulse too long");
   key_after_irq_a: assert property (uplinkIrq |=> keyValid != keyReject)
      else $error("triple verdict missing");
   reject_keeps_asm_a: assert property (keyReject |-> $stable(asmReg))
      else $error("rejected triple changed assembly");
   full_count_a: assert property (asmCount <= 3'h5 && asmFull == (asmCount == 3'h5))
      else $error("assembly count wrong");
   enter_stage_a: assert property (enterCmd && asmFull && stageCount < 4'he
      |=> stageCount == $past(stageCount) + 4'h1) else $error("enter did not stage");
   live_needs_final_a: assert property ($rose(stageLive)
      |-> $past(finalEnterCmd) && stageCount != 4'h0) else $error("live without final enter");
   use_parity_a: assert property ($past(stageLive) && stageLive && $stable(useAddr)
      && useAddr < stageCount |-> ^useWord) else $error("stored word parity not odd");
   tm_hold_a: assert property (tmValid && !tmReady |=> tmValid && $stable(tmByte))
      else $error("telemetry byte dropped");
   cover property (keyReject);
   cover property (enterCmd && asmFull);
   cover property ($rose(stageLive));
endmodule // ukp_props
bind ukp_uplink_keycode_update_path ukp_props u_props (.core_clk(core_clk), .sys_rst(sys_rst),
   .enterCmd(enterCmd), .finalEnterCmd(finalEnterCmd), .useAddr(useAddr), .tmReady(tmReady),
   .uplinkIrq(uplinkIrq), .keyValid(keyValid), .keyReject(keyReject), .asmReg(asmReg),
   .asmCount(asmCount), .asmFull(asmFull), .stageCount(stageCount), .stageLive(stageLive),
   .useWord(useWord), .tmByte(tmByte), .tmValid(tmValid));
`default_nettype wire

// ---- verification/ukp_ground_tx.sv ----
/*
 Ground uplink model sending decoded message symbols.
 Assumes the receiver samples symbols on the rising core_clk edge.
*/
`timescale 1ns/10ps
`default_nettype none
module ukp_ground_tx (
   input  wire logic core_clk,
   output var logic  symValid,
   output var logic  symBit,
   output var logic  msgStart
);
   initial begin
      symValid = 1'b0;
      symBit   = 1'b0;
      msgStart = 1'b0;
   end
   task automatic send(input logic [5:0] addr, input logic [14:0] data);
      logic [21:0] msg;
      msg = {addr, 1'b1, data};
      for (int i = 21; i >= 0; i--) begin
         @(negedge core_clk);
         symValid <= 1'b1;
         msgStart <= (i == 21);
         symBit   <= msg[i];
      end
      @(negedge core_clk);
      symValid <= 1'b0;
      msgStart <= 1'b0;
      // A released line shows the inverse so a stale value is never mistaken for data.
      symBit   <= ~symBit;
   endtask
endmodule // ukp_ground_tx
`default_nettype wire

// ---- verification/ukp_uplink_keycode_update_path_bench.sv ----
/*
 Bench for the uplink keycode update path: uplink, keyboard, enter, echo, final enter.
 Assumes the ground model drives the symbol inputs.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin numChecks++; if ((g) !== (e)) begin numErrors++; \
   $display("wrong value at %0t: output differs", $time); end end
module ukp_uplink_keycode_update_path_bench;
   logic        core_clk = 0, sys_rst = 1, kbdValid = 0, enterCmd = 0;
   logic        finalEnterCmd = 0, tmReady = 0, symVehicleErr = 0;
   logic [3:0]  useAddr = 4'h0;
   logic [4:0]  kbdKeycode = 5'h00;
   logic [7:0]  orderCode = 8'h00;
   wire         symValid, symBit, msgStart, uplinkIrq, keyValid, keyReject, asmFull;
   wire         stageLive, useParityErr, tmValid;
   wire  [14:0] holdArea, asmReg;
   wire  [4:0]  keyOut;
   wire  [2:0]  asmCount;
   wire  [3:0]  stageCount;
   wire  [15:0] useWord;
   wire  [7:0]  tmByte;
   int          numErrors = 0, numChecks = 0;
   always #4 core_clk = ~core_clk;
   ukp_ground_tx gnd (.core_clk(core_clk), .symValid(symValid), .symBit(symBit),
      .msgStart(msgStart));
   ukp_uplink_keycode_update_path DUT (.core_clk(core_clk), .sys_rst(sys_rst), .clkEn(1'b1),
      .symValid(symValid), .symBit(symBit), .symVehicleErr(symVehicleErr), .symSystemErr(1'b0),
      .msgStart(msgStart), .msgEnd(1'b0), .kbdValid(kbdValid), .kbdKeycode(kbdKeycode),
      .enterCmd(enterCmd), .finalEnterCmd(finalEnterCmd), .useAddr(useAddr),
      .orderCode(orderCode), .tmReady(tmReady), .uplinkIrq(uplinkIrq), .holdArea(holdArea),
      .keyValid(keyValid), .keyOut(keyOut), .keyReject(keyReject), .asmReg(asmReg),
      .asmCount(asmCount), .asmFull(asmFull), .stageCount(stageCount), .stageLive(stageLive),
      .useWord(useWord), .useParityErr(useParityErr), .tmByte(tmByte), .tmValid(tmValid));
   task automatic triple(input logic [5:0] a, input logic [14:0] d, input logic ok);
      gnd.send(a, d);
      `CHK(uplinkIrq, 1'b1)
      `CHK(holdArea, d)
      @(posedge core_clk);
      #1;
      `CHK(keyValid, ok)
      `CHK(keyReject, ~ok)
      if (ok) `CHK(keyOut, d[14:10])
      repeat (2) @(negedge core_clk);
      `CHK(asmReg, 15'h0003)
   endtask
   task automatic t_addr;
      gnd.send(6'o52, {5'h14, ~5'h14, 5'h14});
      `CHK(uplinkIrq, 1'b0)
      `CHK(holdArea, {5'h15, 5'h15, 5'h15})
      fork
         gnd.send(6'o12, {5'h14, ~5'h14, 5'h14});
         begin
            repeat (2) @(negedge core_clk);
            symVehicleErr <= 1'b1;
            @(negedge core_clk);
            symVehicleErr <= 1'b0;
         end
      join
      `CHK(uplinkIrq, 1'b0)
      @(posedge core_clk);
      #1;
      `CHK(keyValid, 1'b0)
      `CHK(asmReg, 15'h0003)
      $display("address test done");
   endtask
   task automatic t_kbd;
      for (int d = 4; d <= 8; d++) begin
         @(negedge core_clk);
         kbdValid <= 1'b1;
         kbdKeycode <= {2'b10, d[2:0] | {2'b00, d == 8}};
         @(negedge core_clk);
         kbdValid <= 1'b0;
         `CHK(keyValid, 1'b1)
      end
      repeat (2) @(negedge core_clk);
      `CHK(asmReg, 15'o34567)
      `CHK(asmFull, 1'b1)
      $display("keyboard test done");
   endtask
   task automatic t_enter;
      logic [39:0] w;
      logic [14:0] a;
      int          n;
      a = 15'o34567;
      orderCode <= 8'h03;
      @(negedge core_clk);
      enterCmd <= 1'b1;
      @(negedge core_clk);
      enterCmd <= 1'b0;
      for (int i = 0; i < 5; i++) begin
         n = 0;
         while (tmValid !== 1'b1 && n < 20) begin
            @(negedge core_clk);
            n++;
         end
         `CHK(tmValid, 1'b1)
         @(negedge core_clk);
         w[i*8 +: 8] = tmByte;
         tmReady <= 1'b1;
         @(negedge core_clk);
         tmReady <= 1'b0;
      end
      `CHK(w, {8'h03, ~^a, a, ~^a, a})
      `CHK(stageCount, 4'h1)
      `CHK(useWord, 16'h0000)
      finalEnterCmd <= 1'b1;
      @(negedge core_clk);
      finalEnterCmd <= 1'b0;
      repeat (2) @(negedge core_clk);
      `CHK(stageLive, 1'b1)
      `CHK(useWord, {~^a, a})
      `CHK(useParityErr, 1'b0)
      $display("enter test done");
   endtask
   task automatic summarize;
      $display("checks %0d, mismatches %0d", numChecks, numErrors);
      if (numErrors == 0 && numChecks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      repeat (16) @(negedge core_clk);
      sys_rst <= 1'b0;
      triple(6'o12, {5'h13, ~5'h13, 5'h13}, 1'b1);
      triple(6'o12, {5'h15, 5'h15, 5'h15}, 1'b0);
      $display("uplink test done");
      t_addr;
      t_kbd;
      t_enter;
      summarize;
   end
   initial begin
      #20000;
      numErrors++;
      summarize;
   end
endmodule // ukp_uplink_keycode_update_path_bench
`default_nettype wire
